// *** design/ldo_control_and_fault_handler.sv ***
// Purpose: enable sequencing, soft-start, limits and fault response of two regulators
// Assumes: analog comparators arrive as levels synchronous to clk_i
// Notes:   one ramp timer is shared; regulators start one after the other
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module ldo_control_and_fault_handler
    import ldo_ctrl_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = ldo_ctrl_pkg::RESTART_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // factory configuration
    input  wire logic [1:0]  factory_config_option_i,
    input  wire logic        factory_second_limit_i,
    // general-purpose disable inputs
    input  wire logic [1:0]  gpio_disable_i,
    // analog status
    input  wire logic [1:0]  current_limit_i,
    input  wire logic [1:0]  undervoltage_i,
    input  wire logic        switch_input_over_i,
    // regulator controls
    output logic [1:0]       ldo_enable_o,
    output logic [1:0]       ldo_ramp_active_o,
    output logic [1:0]       ldo_discharge_o,
    output logic [5:0]       ldo1_voltage_code_o,
    output logic [5:0]       ldo2_voltage_code_o,
    output logic [1:0]       ldo_limit_high_o,
    output logic             nchannel_switch_submode_o,
    output logic             pchannel_switch_submode_o,
    output logic             power_good_status_o,
    output logic             undervoltage_fault_state_o,
    output logic             fault_interrupt_n_o
);
    import ldo_ctrl_pkg::*;

    // the wait counter is 24 bits wide and loads RESTART_CYCLES - 1, so the count must be at least 1
    if (RESTART_CYCLES < 1 || RESTART_CYCLES > 32'h00ffffff) begin : g_bad_restart
        $error("RESTART_CYCLES out of range");
    end

    typedef struct packed {
        seq_state_e       seq;
        logic [1:0]       en;
        logic [1:0]       ramping;
        logic [CTRL_W-1:0] ctrl;
        logic [5:0]       vcode1;
        logic [5:0]       vcode2;
        logic [MSK_W-1:0] mask;
        logic             lim2;
        sw_mode_e         mode;
        logic             irq_n;
        logic [23:0]      wait_cnt;
        logic             ov_off;
        logic [9:0]       degl_cnt;
        logic             rd_valid;
        logic [31:0]      rdata;
        logic [1:0]       start_pend;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    ramp_if ramp ();

    ramp_timer u_ramp (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .rq    (ramp.timer)
    );

    // voltage target in millivolts, used only for visibility in status
    function automatic logic [11:0] code_to_mv(input logic [5:0] code);
        code_to_mv = 12'd600 + 12'(code) * 12'd50;
    endfunction

    function automatic logic [23:0] ramp_len(input logic idx, input logic sst_sel,
                                             input sw_mode_e mode);
        if (idx == 1'b0 && mode == MODE_PSW) begin
            ramp_len = 24'h0;
        end else if (idx == 1'b0 && mode == MODE_NSW) begin
            ramp_len = 24'(SST_SHORT_CYC);
        end else begin
            ramp_len = sst_sel ? 24'(SST_LONG_CYC) : 24'(SST_SHORT_CYC);
        end
    endfunction

    // strap decode, used for reset value and every later cycle
    function automatic sw_mode_e decode_mode(input logic [1:0] opt);
        if (opt == FCFG_NSW) begin
            decode_mode = MODE_NSW;
        end else if (opt == FCFG_PSW) begin
            decode_mode = MODE_PSW;
        end else begin
            decode_mode = MODE_LDO;
        end
    endfunction

    logic        acc;
    logic [31:0] wmask;
    logic        uv_hit;
    logic        in_switch;

    always_comb begin
        st_nxt        = st_r;
        ramp.start    = 1'b0;
        ramp.abort    = 1'b0;
        ramp.length   = 24'h0;
        in_switch     = (st_r.mode != MODE_LDO);
        acc           = (avs_read_i || avs_write_i) && !st_r.rd_valid;
        wmask         = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        st_nxt.rd_valid = acc;
        // submode and second limit come from factory straps only
        st_nxt.mode   = decode_mode(factory_config_option_i);
        st_nxt.lim2   = factory_second_limit_i;

        // limit-induced undervoltage; switch mode drops uv on first regulator
        uv_hit = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (st_r.en[i] && current_limit_i[i] && undervoltage_i[i]
                && !st_r.mask[MSK_OC1 + i] && !st_r.mask[MSK_UV]
                && !(i == 0 && in_switch)) begin
                uv_hit = 1'b1;
            end
        end

        // write lands on the answer edge, while the master still holds it
        if (avs_write_i && st_r.rd_valid) begin
            if (avs_address_i == ADDR_CTRL) begin
                st_nxt.ctrl = (st_r.ctrl & ~wmask[CTRL_W-1:0])
                            | (avs_writedata_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
            end else if (avs_address_i == ADDR_VCODE1 && avs_byteenable_i[0]) begin
                st_nxt.vcode1 = avs_writedata_i[5:0];
            end else if (avs_address_i == ADDR_VCODE2 && avs_byteenable_i[0]) begin
                st_nxt.vcode2 = avs_writedata_i[5:0];
            end else if (avs_address_i == ADDR_MASK && avs_byteenable_i[0]) begin
                st_nxt.mask = avs_writedata_i[MSK_W-1:0];
            end
        end

        // register reads
        if (acc && avs_read_i) begin
            if (avs_address_i == ADDR_CTRL) begin
                st_nxt.rdata = {10'h0, st_r.seq == SEQ_UVFAULT, st_r.ov_off,
                                st_r.ramping, st_r.en, 8'h0, st_r.ctrl};
            end else if (avs_address_i == ADDR_VCODE1) begin
                st_nxt.rdata = {4'h0, code_to_mv(st_r.vcode1), 10'h0, st_r.vcode1};
            end else if (avs_address_i == ADDR_VCODE2) begin
                st_nxt.rdata = {4'h0, code_to_mv(st_r.vcode2), 10'h0, st_r.vcode2};
            end else if (avs_address_i == ADDR_MASK) begin
                st_nxt.rdata = {26'h0, st_r.mask};
            end else begin
                st_nxt.rdata = 32'h0;
            end
        end

        // ramp completion clears the ramping flags of both regulators
        if (ramp.done) begin
            st_nxt.ramping = 2'b00;
        end

        // switch over-voltage deglitch and retry
        if (in_switch && switch_input_over_i && !st_r.ov_off && st_r.en[0]) begin
            if (st_r.degl_cnt >= 10'(OV_DEGL_CYC - 1)) begin
                st_nxt.ov_off   = 1'b1;
                st_nxt.en[0]    = 1'b0;
                st_nxt.ramping[0] = 1'b0;
                st_nxt.wait_cnt = 24'(RESTART_CYCLES - 1);
                st_nxt.degl_cnt = 10'h0;
                ramp.abort      = 1'b1;
            end else begin
                st_nxt.degl_cnt = st_r.degl_cnt + 10'h1;
            end
        end else begin
            st_nxt.degl_cnt = 10'h0;
        end

        case (st_r.seq)
            SEQ_START1: begin
                if (!st_r.start_pend[0]) begin
                    st_nxt.en[0]         = 1'b1;
                    st_nxt.ramping[0]    = 1'b1;
                    st_nxt.start_pend[0] = 1'b1;
                    ramp.start  = 1'b1;
                    ramp.length = ramp_len(1'b0, st_r.ctrl[CTRL_SST1], st_r.mode);
                end else if (ramp.done) begin
                    st_nxt.seq = SEQ_START2;
                end
            end
            SEQ_START2: begin
                if (!st_r.start_pend[1]) begin
                    st_nxt.en[1]         = 1'b1;
                    st_nxt.ramping[1]    = 1'b1;
                    st_nxt.start_pend[1] = 1'b1;
                    ramp.start  = 1'b1;
                    ramp.length = ramp_len(1'b1, st_r.ctrl[CTRL_SST2], st_r.mode);
                end else if (ramp.done) begin
                    st_nxt.seq = SEQ_ACTIVE;
                end
            end
            SEQ_ACTIVE: begin
                for (int i = 0; i < 2; i++) begin
                    if (st_r.ctrl[CTRL_OFF1 + i] || gpio_disable_i[i]) begin
                        st_nxt.en[i] = 1'b0;
                    end
                end
                // retry after switch over-voltage
                if (st_r.ov_off) begin
                    if (st_r.wait_cnt == 24'h0) begin
                        st_nxt.ov_off     = 1'b0;
                        st_nxt.en[0]      = 1'b1;
                        st_nxt.ramping[0] = 1'b1;
                        ramp.start  = 1'b1;
                        ramp.length = ramp_len(1'b0, st_r.ctrl[CTRL_SST1], st_r.mode);
                    end else begin
                        st_nxt.wait_cnt = st_r.wait_cnt - 24'h1;
                    end
                end
                if (uv_hit) begin
                    st_nxt.seq      = SEQ_UVFAULT;
                    st_nxt.en       = 2'b00;
                    st_nxt.ramping  = 2'b00;
                    st_nxt.irq_n    = 1'b0;
                    st_nxt.ov_off   = 1'b0;
                    st_nxt.wait_cnt = 24'(RESTART_CYCLES - 1);
                    ramp.abort      = 1'b1;
                end
            end
            SEQ_UVFAULT: begin
                if (st_r.wait_cnt == 24'h0) begin
                    st_nxt.seq        = SEQ_START1;
                    st_nxt.start_pend = 2'b00;
                    st_nxt.irq_n      = 1'b1;
                end else begin
                    st_nxt.wait_cnt = st_r.wait_cnt - 24'h1;
                end
            end
            default: begin
                st_nxt.seq = SEQ_START1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r            <= '0;
            st_r.seq        <= SEQ_START1;
            st_r.vcode1     <= VCODE_RESET;
            st_r.vcode2     <= VCODE_RESET;
            st_r.mask       <= MASK_RESET;
            st_r.irq_n      <= 1'b1;
            // straps apply from the first start, so a switch never gets a stale ramp
            st_r.mode       <= decode_mode(factory_config_option_i);
            st_r.lim2       <= factory_second_limit_i;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_waitrequest_o   = (avs_read_i || avs_write_i) && !st_r.rd_valid;
    assign avs_readdata_o      = st_r.rdata;
    assign ldo_enable_o        = st_r.en;
    assign ldo_ramp_active_o   = st_r.ramping;
    // discharge gated by both off state and its own bit
    assign ldo_discharge_o     = ~st_r.en & {st_r.ctrl[CTRL_DIS2], st_r.ctrl[CTRL_DIS1]};
    assign ldo1_voltage_code_o = st_r.vcode1;
    assign ldo2_voltage_code_o = st_r.vcode2;
    // bit 0: first limit selects high level; in nsw the dedicated bit does
    assign ldo_limit_high_o    = {st_r.lim2, (st_r.mode == MODE_NSW) ?
                                  st_r.ctrl[CTRL_NLIM] : st_r.ctrl[CTRL_LIM1]};
    assign nchannel_switch_submode_o  = (st_r.mode == MODE_NSW);
    assign pchannel_switch_submode_o  = (st_r.mode == MODE_PSW);
    assign power_good_status_o = (st_r.mode != MODE_LDO) && st_r.en[0]
                                 && !current_limit_i[0];
    assign undervoltage_fault_state_o = (st_r.seq == SEQ_UVFAULT);
    assign fault_interrupt_n_o = st_r.irq_n;

    // fault shutdown: everything off and the interrupt pulled low together
    sequence s_all_off;
        ldo_enable_o == 2'b00 && !fault_interrupt_n_o;
    endsequence

    chk_uv_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.seq == SEQ_ACTIVE && uv_hit) |=> s_all_off)
        else $error("undervoltage did not shut down");
    chk_discharge_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ldo_enable_o[0] |-> !ldo_discharge_o[0])
        else $error("discharge while enabled");
    chk_pgood_switch: assert property (@(posedge clk_i) disable iff (rst_i)
        power_good_status_o |-> (ldo_enable_o[0] && !current_limit_i[0]))
        else $error("power good without enable");
    chk_mask_reset: assert property (@(posedge clk_i)
        $fell(rst_i) |-> st_r.mask == MASK_RESET)
        else $error("masks not set at reset");
    chk_psw_noramp: assert property (@(posedge clk_i) disable iff (rst_i)
        (ramp.start && st_r.seq == SEQ_START1 && st_r.mode == MODE_PSW) |=> ramp.done)
        else $error("p switch ramp timed");
    chk_fault_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.seq == SEQ_UVFAULT && st_r.wait_cnt == 24'h0) |=> st_r.seq == SEQ_START1)
        else $error("restart missed");
    chk_active_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.seq == SEQ_ACTIVE && gpio_disable_i[1] && !uv_hit) |=> !ldo_enable_o[1])
        else $error("disable input ignored");
    chk_start_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ldo_enable_o[0]) |-> $past(ramp.start))
        else $error("enable without ramp");
    chk_switch_no_uv: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.seq == SEQ_ACTIVE && in_switch
         && !(st_r.en[1] && current_limit_i[1] && undervoltage_i[1]))
        |=> !undervoltage_fault_state_o)
        else $error("switch undervoltage caused fault");
    chk_ov_retry: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.seq == SEQ_ACTIVE && st_r.ov_off && st_r.wait_cnt == 24'h0 && !uv_hit
         && !st_r.ctrl[CTRL_OFF1] && !gpio_disable_i[0]) |=> ldo_enable_o[0])
        else $error("switch retry missed");
endmodule

// *** shared/ldo_ctrl_pkg.sv ***
// Purpose: constants and types for the dual linear regulator control block
// Assumes: 50 MHz clock, Avalon-MM register access with 32-bit words
// Notes:   times are kept in their own units, cycle counts derived here
package ldo_ctrl_pkg;

    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned SST_SHORT_US = 200;
    localparam int unsigned SST_LONG_US  = 360;
    localparam int unsigned OV_DEGL_US   = 10;
    localparam int unsigned RESTART_MS   = 100;

    // least times scale by whole clock cycles per microsecond or millisecond
    localparam int unsigned SST_SHORT_CYC = (SST_SHORT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SST_LONG_CYC  = (SST_LONG_US * (CLK_HZ / 1_000_000));
    localparam int unsigned OV_DEGL_CYC   = (OV_DEGL_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RESTART_CYC   = (RESTART_MS * (CLK_HZ / 1_000));

    // register word addresses (byte offsets)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_VCODE1 = 4'h4;
    localparam logic [3:0] ADDR_VCODE2 = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hc;

    // control register fields
    localparam int unsigned CTRL_OFF1  = 0;
    localparam int unsigned CTRL_OFF2  = 1;
    localparam int unsigned CTRL_DIS1  = 2;
    localparam int unsigned CTRL_DIS2  = 3;
    localparam int unsigned CTRL_SST1  = 4;
    localparam int unsigned CTRL_SST2  = 5;
    localparam int unsigned CTRL_LIM1  = 6;
    localparam int unsigned CTRL_NLIM  = 7;
    localparam int unsigned CTRL_W     = 8;

    // status fields (read in the control word, bits 16 and up)
    localparam int unsigned STAT_BASE  = 16;

    // mask register fields, all masked at reset
    localparam int unsigned MSK_OC1    = 0;
    localparam int unsigned MSK_OC2    = 1;
    localparam int unsigned MSK_OC     = 2;
    localparam int unsigned MSK_WARN   = 3;
    localparam int unsigned MSK_OV     = 4;
    localparam int unsigned MSK_UV     = 5;
    localparam int unsigned MSK_W      = 6;
    localparam logic [MSK_W-1:0] MASK_RESET = 6'h3f;

    localparam logic [5:0] VCODE_RESET = 6'h18;

    // factory strap encodings of the first regulator's role
    localparam logic [1:0] FCFG_NSW    = 2'b01;
    localparam logic [1:0] FCFG_PSW    = 2'b10;

    typedef enum logic [1:0] {
        MODE_LDO,
        MODE_NSW,
        MODE_PSW
    } sw_mode_e;

    typedef enum logic [2:0] {
        SEQ_START1,
        SEQ_START2,
        SEQ_ACTIVE,
        SEQ_UVFAULT
    } seq_state_e;

endpackage

// *** shared/ramp_if.sv ***
// Purpose: carries one soft-start request and its completion
// Assumes: single clock
// Notes:   start is a one-cycle pulse, busy stands until the ramp ends
`timescale 1ns/1ps
interface ramp_if;
    logic        start;
    logic        abort;
    logic [23:0] length;
    logic        busy;
    logic        done;
    modport ctrl (output start, output abort, output length, input busy, input done);
    modport timer(input start, input abort, input length, output busy, output done);
endinterface

// *** design/ramp_timer.sv ***
// Purpose: down-counter timing one soft-start ramp
// Assumes: length of zero means no timed ramp, done follows at once
// Notes:   a new start restarts the count
`timescale 1ns/1ps
module ramp_timer (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // ramp request
    ramp_if.timer     rq
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        busy;
        logic        done;
    } rt_s;

    rt_s st_r;
    rt_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (rq.abort) begin
            st_nxt.busy = 1'b0;
        end else if (rq.start) begin
            if (rq.length == 24'h0) begin
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.busy = 1'b1;
                st_nxt.cnt  = rq.length - 24'h1;
            end
        end else if (st_r.busy) begin
            if (st_r.cnt == 24'h0) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 24'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rq.busy = st_r.busy;
    assign rq.done = st_r.done;
endmodule

// *** test/ldo_plant_model.sv ***
// Purpose: behavioural regulator plant that answers the enables with limit and droop
// Assumes: the bench commands an overload per regulator
// Notes:   droop lags limiting by one cycle, as a real output sags after the limit
`timescale 1ns/1ps
module ldo_plant_model (
    // clock
    input  wire logic       clk_i,
    // bench command and regulator enables
    input  wire logic [1:0] overload_i,
    input  wire logic [1:0] enable_i,
    // analog status back to the block
    output logic      [1:0] current_limit_o,
    output logic      [1:0] undervoltage_o
);
    // a disabled regulator draws nothing, so it cannot limit, and its sag ends one cycle later
    assign current_limit_o = enable_i & overload_i;
    initial undervoltage_o = 2'b00;
    always @(posedge clk_i) begin
        undervoltage_o <= current_limit_o;
    end
endmodule

// *** test/tb_ldo_control_and_fault_handler.sv ***
// Purpose: self-checking bench for the dual regulator control block
// Assumes: restart delay shortened to 50 cycles, soft-start times kept full
// Notes:   reads are checked by a monitor against notes queued by the driver
`timescale 1ns/1ps
module tb_ldo_control_and_fault_handler;
    import ldo_ctrl_pkg::*;
    localparam int unsigned RC = 50;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [1:0]  fcfg = 2'b00;
    logic        f2lim = 1'b0;
    logic [1:0]  gdis = 2'b00;
    logic [1:0]  ovl = 2'b00;
    logic        sov = 1'b0;
    logic [31:0] rdat;
    logic        wreq;
    logic [1:0]  clim, uvs, en, ramp, dis, lim;
    logic [5:0]  code1, code2;
    logic        nsw, psw, pg, uvf, irq_n;
    logic [5:0]  v;
    logic [63:0] note;
    logic [63:0] rd_q[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    int          seed = 28129;
    int          w;

    ldo_control_and_fault_handler #(.RESTART_CYCLES(RC)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .factory_config_option_i(fcfg), .factory_second_limit_i(f2lim),
        .gpio_disable_i(gdis), .current_limit_i(clim), .undervoltage_i(uvs),
        .switch_input_over_i(sov),
        .ldo_enable_o(en), .ldo_ramp_active_o(ramp), .ldo_discharge_o(dis),
        .ldo1_voltage_code_o(code1), .ldo2_voltage_code_o(code2),
        .ldo_limit_high_o(lim), .nchannel_switch_submode_o(nsw),
        .pchannel_switch_submode_o(psw), .power_good_status_o(pg),
        .undervoltage_fault_state_o(uvf), .fault_interrupt_n_o(irq_n)
    );

    ldo_plant_model u_plant (
        .clk_i(clk_i), .overload_i(ovl), .enable_i(en),
        .current_limit_o(clim), .undervoltage_o(uvs)
    );

    always #10 clk_i = ~clk_i;

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] near(input int a, input int e);
        return {31'h0, (a >= e - 3) && (a <= e + 3)};
    endfunction

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [3:0] a, input logic wn, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        adr <= a;
        wr_s <= wn;
        rd_s <= !wn;
        wdat <= d;
        be <= b;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        if (wreq !== 1'b0) fail_count++;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back({e, m});
        bus(a, 1'b0, 32'h0, 4'hf);
    endtask

    // dly: cycles until the ramp shows, then the ramp length is compared
    task automatic wait_ramp(input int i, input int e, output int dly);
        int n;
        dly = 0;
        n = 0;
        @(negedge clk_i);
        while (ramp[i] !== 1'b1 && dly < 40000) begin
            @(negedge clk_i);
            dly++;
        end
        while (ramp[i] === 1'b1 && n < 40000) begin
            @(negedge clk_i);
            n++;
        end
        check_val(near(n, e), 32'h1);
        @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (!rst_i && rd_s && !wreq && rd_q.size() > 0) begin
            note = rd_q.pop_front();
            check_val(rdat & note[31:0], note[63:32]);
        end
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        @(posedge clk_i);
        f2lim <= 1'($random(seed));
        repeat (11) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_ramp(0, SST_SHORT_CYC, w);
        wait_ramp(1, SST_SHORT_CYC, w);
        check_val(en, 2'b11);
        rd(ADDR_MASK, {26'h0, MASK_RESET}, 32'h3f);
        rd(ADDR_VCODE1, {4'h0, 12'd1800, 10'h0, VCODE_RESET}, 32'h0fff003f);
        // codes 15..33 keep the output within a quarter of the 1.8 V default
        v = 6'(15 + ($unsigned($random(seed)) % 19));
        bus(ADDR_VCODE1, 1'b1, {26'h0, v}, 4'hf);
        repeat (2) @(posedge clk_i);
        check_val(code1, v);
        rd(ADDR_VCODE1, {4'h0, 12'(600 + 50 * v), 10'h0, v}, 32'h0fff003f);
        bus(ADDR_VCODE2, 1'b1, 32'h3f, 4'h0);
        repeat (2) @(posedge clk_i);
        check_val(code2, VCODE_RESET);
        rd(4'h2, 32'h0, 32'hffffffff);
        // masked overload must not shut anything down
        ovl <= 2'b10;
        repeat (20) @(posedge clk_i);
        check_val({uvf, irq_n, en}, 4'b0111);
        ovl <= 2'b00;
        bus(ADDR_CTRL, 1'b1, 32'h20, 4'hf);
        bus(ADDR_MASK, 1'b1, 32'h0, 4'hf);
        rd(ADDR_MASK, 32'h0, 32'h3f);
        ovl <= 2'b10;
        w = 0;
        while (uvf !== 1'b1 && w < 20) begin
            @(negedge clk_i);
            w++;
        end
        check_val({uvf, irq_n, en}, 4'b1000);
        @(posedge clk_i);
        ovl <= 2'b00;
        wait_ramp(0, SST_SHORT_CYC, w);
        check_val(near(w, RC), 32'h1);
        wait_ramp(1, SST_LONG_CYC, w);
        check_val({uvf, irq_n, en}, 4'b0111);
        bus(ADDR_CTRL, 1'b1, 32'h45, 4'hf);
        repeat (3) @(posedge clk_i);
        check_val({en, dis}, 4'b1001);
        check_val(lim, {f2lim, 1'b1});
        gdis <= 2'b10;
        repeat (3) @(posedge clk_i);
        check_val({en, dis}, 4'b0001);
        gdis <= 2'b00;
        bus(ADDR_CTRL, 1'b1, 32'h80, 4'hf);
        fcfg <= 2'b01;
        repeat (3) @(posedge clk_i);
        check_val({nsw, psw, lim[0]}, 3'b101);
        ovl <= 2'b01;
        repeat (20) @(posedge clk_i);
        check_val({pg, uvf}, 2'b00);
        ovl <= 2'b00;
        fcfg <= 2'b10;
        repeat (3) @(posedge clk_i);
        check_val({nsw, psw, lim[0]}, 3'b010);
        // second reset in mid-run with the p-channel switch strapped
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_ramp(0, 0, w);
        wait_ramp(1, SST_SHORT_CYC, w);
        rd(ADDR_MASK, {26'h0, MASK_RESET}, 32'h3f);
        check_val({pg, en}, 3'b111);
        bus(ADDR_MASK, 1'b1, 32'h0, 4'hf);
        ovl <= 2'b01;
        repeat (20) @(posedge clk_i);
        check_val({pg, uvf, en}, 4'b0011);
        ovl <= 2'b00;
        // over-voltage held past the deglitch time turns the switch off, then it retries
        sov <= 1'b1;
        repeat (400) @(negedge clk_i);
        check_val(en, 2'b11);
        w = 400;
        while (en[0] === 1'b1 && w < 1000) begin
            @(negedge clk_i);
            w++;
        end
        check_val(near(w, OV_DEGL_CYC), 32'h1);
        @(posedge clk_i);
        sov <= 1'b0;
        w = 0;
        while (en[0] !== 1'b1 && w < 200) begin
            @(negedge clk_i);
            w++;
        end
        check_val(near(w, RC), 32'h1);
        @(posedge clk_i);
        check_val(rd_q.size(), 32'h0);
        tally_and_finish();
    end
endmodule
